// ### pqed_core_model.sv
// Purpose: processing-core model issuing one sample strobe per pass
// Assumes: free-running pass rate
// Notes: bench shortens the period so the run stays brief
`default_nettype none

module pqed_core_model #(
    parameter int unsigned PERIOD = 1250
) (
    input  wire logic clk,
    input  wire logic rst_b,
    output logic      sample_valid
);
    logic [15:0] cnt_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg      <= 16'h0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= (cnt_reg == 16'(PERIOD - 1));
            cnt_reg      <= (cnt_reg == 16'(PERIOD - 1)) ? 16'h0 : cnt_reg + 16'h1;
        end
    end
endmodule

`default_nettype wire

// ### pqed_half_cycle_counter.sv
// Purpose: half-cycle time base for the peak windows
// Assumes: zero-crossing pulses already filtered to the selected phases
// Notes: a limit of zero behaves as one half cycle
`default_nettype none

module pqed_half_cycle_counter #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             zero_cross,
    input  wire logic             restart,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  period_end
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             period_end;
    } pqed_hcc_regs_type;

    pqed_hcc_regs_type st_reg;
    pqed_hcc_regs_type st_next;
    logic [WIDTH-1:0]  bumped;

    assign bumped     = st_reg.count + 1'b1;
    assign period_end = st_reg.period_end;

    always_comb begin
        st_next            = st_reg;
        st_next.period_end = 1'b0;
        if (restart) begin
            // counter otherwise free-runs, so the first window would be short
            st_next.count = '0; // [R2]
        end else if (zero_cross) begin
            if (bumped >= limit) begin
                st_next.count      = '0;
                st_next.period_end = 1'b1;
            end else begin
                st_next.count = bumped;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// ### pqed_pkg.sv
// Purpose: shared constants and types for the power quality event detector
// Assumes: one 10 MHz clock, sample strobes from the processing core at 8 kHz
// Notes: register offsets are word offsets on the serial register port
// Operation
// R1: host reads status, then current or voltage max register, then writes ones back
// R2: peak half-cycle count write with phases selected restarts the zero-crossing counter
// R3: absolute voltage and current samples compared against unsigned 24-bit thresholds
// R4: high-voltage event sets status bit 18 and phase bits [11:9]
// R5: enabled high-voltage event pulls interrupt pin low as flags set
// R6: writing status bit 18 clears the flag, phase bits [11:9], releases pin
// R7: high-current event sets bit 17, phase bits [5:3], pulls pin if enabled
// R8: writing status bit 17 clears the flag and phase bits [5:3]
// R9: threshold at full scale never detects, zero threshold always detects
// R10: both 24-bit thresholds read as 32-bit words, top eight bits zero
// R11: each 125 us the three phase currents are summed into 28-bit signed total
// R12: compute-done flag, compute status bit 17, marks a fresh total
// R13: total versus neutral magnitude difference above threshold sets status bit 20
// R14: enabled mismatch pulls pin low; writing bit 20 clears it
// R15: mismatch threshold resets to zero; zero or negative always triggers
// R16: host should program a positive mismatch threshold after reset
// R17: 28-bit total reads as 32-bit word with top four bits zero
// R18: mismatch threshold reads with top four bits zero, sign-extended to 28 bits
// R19: config three bit 2 routes the total instead of neutral to neutral rms
// R20: end of each peak period sets bit 23 for current, bit 24 for voltage
// R21: one computation pass per 8 kHz sample sets compute-done at its end
// R22: interrupt pin stays low while any enabled flag is set
// R23: comparisons evaluated once per sample set, on the sample-valid strobe; the mismatch comparison runs in the cycle after the strobe
`default_nettype none

package pqed_pkg;

    localparam int unsigned REF_CLK_PERIOD_NS = 100;
    localparam int unsigned SAMPLE_PERIOD_NS  = 125000;
    localparam int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / REF_CLK_PERIOD_NS;

    localparam logic [7:0] ADDR_EVENT_STATUS     = 8'h00;
    localparam logic [7:0] ADDR_EVENT_ENABLE     = 8'h01;
    localparam logic [7:0] ADDR_PER_PHASE_STATUS = 8'h02;
    localparam logic [7:0] ADDR_COMPUTE_STATUS   = 8'h03;
    localparam logic [7:0] ADDR_MEASURE_MODE     = 8'h04;
    localparam logic [7:0] ADDR_PEAK_HALF_CYCLES = 8'h05;
    localparam logic [7:0] ADDR_HIGH_VOLT_THR    = 8'h06;
    localparam logic [7:0] ADDR_HIGH_CURR_THR    = 8'h07;
    localparam logic [7:0] ADDR_PHASE_CURR_TOTAL = 8'h08;
    localparam logic [7:0] ADDR_MISMATCH_THR     = 8'h09;
    localparam logic [7:0] ADDR_CONFIG_THREE     = 8'h0a;
    localparam logic [7:0] ADDR_CURRENT_MAX      = 8'h0b;
    localparam logic [7:0] ADDR_VOLTAGE_MAX      = 8'h0c;

    localparam int unsigned BIT_HIGH_CURR       = 17;
    localparam int unsigned BIT_HIGH_VOLT       = 18;
    localparam int unsigned BIT_MISMATCH        = 20;
    localparam int unsigned BIT_CURR_MAX_DONE   = 23;
    localparam int unsigned BIT_VOLT_MAX_DONE   = 24;
    localparam int unsigned BIT_COMPUTE_DONE    = 17;
    localparam int unsigned BIT_NEUTRAL_SRC_SEL = 2;
    localparam int unsigned LSB_HIGH_VOLT_PHASE = 9;
    localparam int unsigned LSB_HIGH_CURR_PHASE = 3;
    localparam int unsigned LSB_PEAK_PHASE_SEL  = 2;
    localparam int unsigned LSB_MAX_PHASE       = 24;

    localparam logic [31:0] EVENT_STATUS_MASK   = 32'h0196_0000;
    localparam logic [23:0] FULL_SCALE_LEVEL    = 24'h51_4791;
    localparam logic [23:0] RST_THRESHOLD       = 24'h00_0000;
    localparam logic [23:0] RST_MISMATCH_THR    = 24'h00_0000;
    localparam logic [7:0]  RST_PEAK_HALF_CYC   = 8'h00;

    typedef enum logic [0:0] {
        CALC_IDLE    = 1'b0,
        CALC_COMPARE = 1'b1
    } pqed_calc_type;

    typedef struct packed {
        pqed_calc_type calc;
        logic [31:0]   ev_status;
        logic [31:0]   ev_enable;
        logic [2:0]    hv_phase;
        logic [2:0]    hc_phase;
        logic          done;
        logic [2:0]    peak_sel;
        logic [7:0]    peak_cyc;
        logic [23:0]   hv_thr;
        logic [23:0]   hc_thr;
        logic [27:0]   total;
        logic [23:0]   mm_thr;
        logic          neutral_sel;
        logic [26:0]   imax;
        logic [26:0]   vmax;
        logic [23:0]   i_run;
        logic [2:0]    i_ph;
        logic [23:0]   v_run;
        logic [2:0]    v_ph;
        logic [23:0]   neutral_abs;
        logic          int_n;
        logic [31:0]   rdata;
        logic [27:0]   nrms_src;
    } pqed_top_regs_type;

endpackage

`default_nettype wire

// ### pqed_top.sv
// Purpose: over-level, current mismatch and peak-window event detection
// Assumes: samples are signed 24-bit and steady while SAMPLE_VALID is high
// Notes: register port is word wide; reads answer one cycle after REG_RD
`default_nettype none

module pqed_top #(
    parameter int unsigned SAMPLE_WIDTH = 24,
    parameter int unsigned CYC_WIDTH    = 8
) (
    input  wire logic                    REF_CLK,
    input  wire logic                    RST_B,
    input  wire logic                    SAMPLE_VALID,
    input  wire logic [SAMPLE_WIDTH-1:0] PHASE_A_VOLTAGE_SAMPLE,
    input  wire logic [SAMPLE_WIDTH-1:0] PHASE_B_VOLTAGE_SAMPLE,
    input  wire logic [SAMPLE_WIDTH-1:0] PHASE_C_VOLTAGE_SAMPLE,
    input  wire logic [SAMPLE_WIDTH-1:0] PHASE_A_CURRENT_SAMPLE,
    input  wire logic [SAMPLE_WIDTH-1:0] PHASE_B_CURRENT_SAMPLE,
    input  wire logic [SAMPLE_WIDTH-1:0] PHASE_C_CURRENT_SAMPLE,
    input  wire logic [SAMPLE_WIDTH-1:0] NEUTRAL_CURRENT_SAMPLE,
    input  wire logic                    ZERO_CROSS_A,
    input  wire logic                    ZERO_CROSS_B,
    input  wire logic                    ZERO_CROSS_C,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    input  wire logic [7:0]              REG_ADDR,
    input  wire logic [31:0]             REG_WDATA,
    output logic      [31:0]             REG_RDATA,
    output logic                         EVENT_INT_N,
    output logic      [27:0]             NEUTRAL_RMS_SOURCE
);

    pqed_pkg::pqed_top_regs_type st_reg;
    pqed_pkg::pqed_top_regs_type st_next;

    logic [2:0]  zero_cross;
    logic        period_end;
    logic        restart;
    logic [23:0] v_abs [3];
    logic [23:0] i_abs [3];
    logic [2:0]  hv_hit;
    logic [2:0]  hc_hit;
    logic [27:0] sum;
    logic [27:0] total_abs;
    logic [27:0] diff;
    logic [27:0] thr_ext;
    logic [31:0] ev_set;
    logic [31:0] ev_clr;

    function automatic logic [23:0] abs24(input logic [23:0] v);
        abs24 = v[23] ? (~v + 24'h00_0001) : v;
    endfunction

    function automatic logic [27:0] abs28(input logic [27:0] v);
        abs28 = v[27] ? (~v + 28'h000_0001) : v;
    endfunction

    function automatic logic [27:0] sext28(input logic [23:0] v);
        sext28 = {{4{v[23]}}, v};
    endfunction

    // zero threshold forces detection even on a zero sample
    function automatic logic over_level(input logic [23:0] mag, input logic [23:0] thr);
        over_level = (thr == 24'h00_0000)
                  || ((thr != pqed_pkg::FULL_SCALE_LEVEL) && (mag > thr)); // [R9] [R3]
    endfunction

    function automatic logic wr_at(input logic [7:0] addr);
        wr_at = REG_WR && (REG_ADDR == addr);
    endfunction

    assign zero_cross = {ZERO_CROSS_C, ZERO_CROSS_B, ZERO_CROSS_A};
    assign restart    = wr_at(pqed_pkg::ADDR_PEAK_HALF_CYCLES) && (|st_reg.peak_sel); // [R2]

    pqed_half_cycle_counter #(
        .WIDTH (CYC_WIDTH)
    ) u_half_cycles (
        .clk        (REF_CLK),
        .rst_b      (RST_B),
        .zero_cross (|(zero_cross & st_reg.peak_sel)),
        .restart    (restart),
        .limit      (st_reg.peak_cyc),
        .period_end (period_end)
    );

    always_comb begin
        v_abs[0] = abs24(PHASE_A_VOLTAGE_SAMPLE);
        v_abs[1] = abs24(PHASE_B_VOLTAGE_SAMPLE);
        v_abs[2] = abs24(PHASE_C_VOLTAGE_SAMPLE);
        i_abs[0] = abs24(PHASE_A_CURRENT_SAMPLE);
        i_abs[1] = abs24(PHASE_B_CURRENT_SAMPLE);
        i_abs[2] = abs24(PHASE_C_CURRENT_SAMPLE);
        for (int k = 0; k < 3; k++) begin
            hv_hit[k] = over_level(v_abs[k], st_reg.hv_thr); // [R3]
            hc_hit[k] = over_level(i_abs[k], st_reg.hc_thr); // [R3]
        end
    end

    assign sum = sext28(PHASE_A_CURRENT_SAMPLE)
               + sext28(PHASE_B_CURRENT_SAMPLE)
               + sext28(PHASE_C_CURRENT_SAMPLE); // [R11]

    assign total_abs = abs28(st_reg.total);
    assign diff      = abs28(total_abs - {4'h0, st_reg.neutral_abs}); // [R13]
    assign thr_ext   = sext28(st_reg.mm_thr); // [R18]
    assign ev_clr    = wr_at(pqed_pkg::ADDR_EVENT_STATUS)
                     ? (REG_WDATA & pqed_pkg::EVENT_STATUS_MASK) : 32'h0000_0000;

    always_comb begin
        st_next = st_reg;
        ev_set  = 32'h0000_0000;

        // window close latches the maxima before this cycle's sample is folded in
        if (period_end) begin
            st_next.imax  = {st_reg.i_ph, st_reg.i_run};
            st_next.vmax  = {st_reg.v_ph, st_reg.v_run};
            st_next.i_run = 24'h00_0000;
            st_next.v_run = 24'h00_0000;
            st_next.i_ph  = 3'h0;
            st_next.v_ph  = 3'h0;
            ev_set[pqed_pkg::BIT_CURR_MAX_DONE] = 1'b1; // [R20]
            ev_set[pqed_pkg::BIT_VOLT_MAX_DONE] = 1'b1; // [R20]
        end
        if (restart) begin
            st_next.i_run = 24'h00_0000;
            st_next.v_run = 24'h00_0000;
            st_next.i_ph  = 3'h0;
            st_next.v_ph  = 3'h0;
        end

        if (SAMPLE_VALID) begin // [R23]
            if (|hv_hit) begin
                ev_set[pqed_pkg::BIT_HIGH_VOLT] = 1'b1; // [R4]
            end
            if (|hc_hit) begin
                ev_set[pqed_pkg::BIT_HIGH_CURR] = 1'b1; // [R7]
            end
            st_next.total       = sum; // [R11]
            st_next.neutral_abs = abs24(NEUTRAL_CURRENT_SAMPLE);
            st_next.calc        = pqed_pkg::CALC_COMPARE;
            st_next.nrms_src    = st_reg.neutral_sel
                                ? sum : sext28(NEUTRAL_CURRENT_SAMPLE); // [R19]
            for (int k = 0; k < 3; k++) begin
                if (st_reg.peak_sel[k] && (i_abs[k] > st_next.i_run)) begin
                    st_next.i_run = i_abs[k];
                    st_next.i_ph  = 3'(1 << k);
                end
                if (st_reg.peak_sel[k] && (v_abs[k] > st_next.v_run)) begin
                    st_next.v_run = v_abs[k];
                    st_next.v_ph  = 3'(1 << k);
                end
            end
        end else begin
            unique case (st_reg.calc)
                pqed_pkg::CALC_IDLE: begin
                    st_next.calc = pqed_pkg::CALC_IDLE;
                end
                pqed_pkg::CALC_COMPARE: begin
                    // a non-positive threshold always trips, even on a zero difference
                    if (st_reg.mm_thr[23] || (st_reg.mm_thr == 24'h00_0000)
                        || ($signed(diff) > $signed(thr_ext))) begin
                        ev_set[pqed_pkg::BIT_MISMATCH] = 1'b1; // [R13] [R15]
                    end
                    st_next.calc = pqed_pkg::CALC_IDLE;
                end
            endcase
        end

        // set wins over a clear landing in the same cycle
        st_next.ev_status = (st_reg.ev_status & ~ev_clr) | ev_set; // [R6] [R8] [R14]
        if (ev_clr[pqed_pkg::BIT_HIGH_VOLT]) begin
            st_next.hv_phase = 3'h0; // [R6]
        end
        if (ev_clr[pqed_pkg::BIT_HIGH_CURR]) begin
            st_next.hc_phase = 3'h0; // [R8]
        end
        if (SAMPLE_VALID) begin
            st_next.hv_phase = st_next.hv_phase | hv_hit; // [R4]
            st_next.hc_phase = st_next.hc_phase | hc_hit; // [R7]
        end

        if (wr_at(pqed_pkg::ADDR_COMPUTE_STATUS) && REG_WDATA[pqed_pkg::BIT_COMPUTE_DONE]) begin
            st_next.done = 1'b0;
        end
        if ((st_reg.calc == pqed_pkg::CALC_COMPARE) && !SAMPLE_VALID) begin
            st_next.done = 1'b1; // [R12] [R21]
        end

        if (wr_at(pqed_pkg::ADDR_EVENT_ENABLE)) begin
            st_next.ev_enable = REG_WDATA & pqed_pkg::EVENT_STATUS_MASK;
        end
        if (wr_at(pqed_pkg::ADDR_MEASURE_MODE)) begin
            st_next.peak_sel = REG_WDATA[pqed_pkg::LSB_PEAK_PHASE_SEL +: 3];
        end
        if (wr_at(pqed_pkg::ADDR_PEAK_HALF_CYCLES)) begin
            st_next.peak_cyc = REG_WDATA[CYC_WIDTH-1:0];
        end
        if (wr_at(pqed_pkg::ADDR_HIGH_VOLT_THR)) begin
            st_next.hv_thr = REG_WDATA[23:0];
        end
        if (wr_at(pqed_pkg::ADDR_HIGH_CURR_THR)) begin
            st_next.hc_thr = REG_WDATA[23:0];
        end
        if (wr_at(pqed_pkg::ADDR_MISMATCH_THR)) begin
            st_next.mm_thr = REG_WDATA[23:0];
        end
        if (wr_at(pqed_pkg::ADDR_CONFIG_THREE)) begin
            st_next.neutral_sel = REG_WDATA[pqed_pkg::BIT_NEUTRAL_SRC_SEL];
        end

        // pin follows the flags in the very edge they change
        st_next.int_n = ~|(st_next.ev_status & st_next.ev_enable); // [R5] [R7] [R14] [R22]

        if (REG_RD) begin
            unique case (REG_ADDR)
                pqed_pkg::ADDR_EVENT_STATUS:     st_next.rdata = st_reg.ev_status;
                pqed_pkg::ADDR_EVENT_ENABLE:     st_next.rdata = st_reg.ev_enable;
                pqed_pkg::ADDR_PER_PHASE_STATUS: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rdata[pqed_pkg::LSB_HIGH_VOLT_PHASE +: 3] = st_reg.hv_phase;
                    st_next.rdata[pqed_pkg::LSB_HIGH_CURR_PHASE +: 3] = st_reg.hc_phase;
                end
                pqed_pkg::ADDR_COMPUTE_STATUS: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rdata[pqed_pkg::BIT_COMPUTE_DONE] = st_reg.done;
                end
                pqed_pkg::ADDR_MEASURE_MODE: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rdata[pqed_pkg::LSB_PEAK_PHASE_SEL +: 3] = st_reg.peak_sel;
                end
                pqed_pkg::ADDR_PEAK_HALF_CYCLES: st_next.rdata = 32'(st_reg.peak_cyc);
                pqed_pkg::ADDR_HIGH_VOLT_THR:    st_next.rdata = {8'h00, st_reg.hv_thr}; // [R10]
                pqed_pkg::ADDR_HIGH_CURR_THR:    st_next.rdata = {8'h00, st_reg.hc_thr}; // [R10]
                pqed_pkg::ADDR_PHASE_CURR_TOTAL: st_next.rdata = {4'h0, st_reg.total};   // [R17]
                pqed_pkg::ADDR_MISMATCH_THR:     st_next.rdata = {4'h0, thr_ext};        // [R18]
                pqed_pkg::ADDR_CONFIG_THREE: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rdata[pqed_pkg::BIT_NEUTRAL_SRC_SEL] = st_reg.neutral_sel;
                end
                // host reads these right after status to learn the phase
                pqed_pkg::ADDR_CURRENT_MAX:      st_next.rdata = {5'h00, st_reg.imax}; // [R1]
                pqed_pkg::ADDR_VOLTAGE_MAX:      st_next.rdata = {5'h00, st_reg.vmax}; // [R1]
                default:                         st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg          <= '0;
            st_reg.calc     <= pqed_pkg::CALC_IDLE;
            st_reg.hv_thr   <= pqed_pkg::RST_THRESHOLD;
            st_reg.hc_thr   <= pqed_pkg::RST_THRESHOLD;
            st_reg.mm_thr   <= pqed_pkg::RST_MISMATCH_THR; // [R15]
            st_reg.peak_cyc <= pqed_pkg::RST_PEAK_HALF_CYC;
            st_reg.int_n    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign REG_RDATA          = st_reg.rdata;
    assign EVENT_INT_N        = st_reg.int_n;
    assign NEUTRAL_RMS_SOURCE = st_reg.nrms_src;

endmodule

`default_nettype wire

// ### pqed_top_sva.sv
// Purpose: port-level checks of the event detector
// Assumes: bound to pqed_top
// Notes: no register shadows; outputs tied to causes at the ports
`default_nettype none

module pqed_top_sva #(
    parameter int unsigned SAMPLE_WIDTH = 24,
    parameter int unsigned CYC_WIDTH    = 8
) (
    input wire logic                    REF_CLK,
    input wire logic                    RST_B,
    input wire logic                    SAMPLE_VALID,
    input wire logic [SAMPLE_WIDTH-1:0] PHASE_A_VOLTAGE_SAMPLE,
    input wire logic [SAMPLE_WIDTH-1:0] PHASE_B_VOLTAGE_SAMPLE,
    input wire logic [SAMPLE_WIDTH-1:0] PHASE_C_VOLTAGE_SAMPLE,
    input wire logic [SAMPLE_WIDTH-1:0] PHASE_A_CURRENT_SAMPLE,
    input wire logic [SAMPLE_WIDTH-1:0] PHASE_B_CURRENT_SAMPLE,
    input wire logic [SAMPLE_WIDTH-1:0] PHASE_C_CURRENT_SAMPLE,
    input wire logic [SAMPLE_WIDTH-1:0] NEUTRAL_CURRENT_SAMPLE,
    input wire logic                    ZERO_CROSS_A,
    input wire logic                    ZERO_CROSS_B,
    input wire logic                    ZERO_CROSS_C,
    input wire logic                    REG_WR,
    input wire logic                    REG_RD,
    input wire logic [7:0]              REG_ADDR,
    input wire logic [31:0]             REG_WDATA,
    input wire logic [31:0]             REG_RDATA,
    input wire logic                    EVENT_INT_N,
    input wire logic [27:0]             NEUTRAL_RMS_SOURCE
);
    wire logic        zc_any = ZERO_CROSS_A | ZERO_CROSS_B | ZERO_CROSS_C;
    wire logic [27:0] nsx    = 28'($signed(NEUTRAL_CURRENT_SAMPLE));
    wire logic [27:0] sum28  = 28'($signed(PHASE_A_CURRENT_SAMPLE))
                             + 28'($signed(PHASE_B_CURRENT_SAMPLE))
                             + 28'($signed(PHASE_C_CURRENT_SAMPLE));

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);

    a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (REG_RD && REG_ADDR > 8'h0c |=> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    a_thr_pad: assert property (REG_RD && (REG_ADDR == 8'h06 || REG_ADDR == 8'h07)
        |=> REG_RDATA[31:24] == 8'h0)
        else $error("threshold top byte not zero");
    a_total_pad: assert property (REG_RD && REG_ADDR == 8'h08 |=> REG_RDATA[31:28] == 4'h0)
        else $error("total top nibble not zero");
    a_mm_sext: assert property (REG_RD && REG_ADDR == 8'h09
        |=> REG_RDATA[31:28] == 4'h0 && REG_RDATA[27:24] == {4{REG_RDATA[23]}})
        else $error("mismatch threshold not sign extended");
    a_int_release: assert property ($rose(EVENT_INT_N) |-> $past(REG_WR))
        else $error("interrupt released without a write");
    a_int_cause: assert property ($fell(EVENT_INT_N) |-> $past(SAMPLE_VALID)
        || $past(SAMPLE_VALID, 2) || $past(REG_WR) || $past(zc_any, 2)
        || $past(zc_any, 3) || $past(zc_any, 4))
        else $error("interrupt fell without a cause");
    a_nrms_hold: assert property (!SAMPLE_VALID |=> $stable(NEUTRAL_RMS_SOURCE))
        else $error("neutral source moved between samples");
    a_nrms_value: assert property (SAMPLE_VALID |=> NEUTRAL_RMS_SOURCE == $past(sum28)
        || NEUTRAL_RMS_SOURCE == $past(nsx))
        else $error("neutral source neither total nor neutral");
endmodule

`default_nettype wire

// ### tb_pqed_top.sv
// Purpose: directed register-level tests of the event detector
// Assumes: core model strobes every 20 cycles
// Notes: expectations follow from the thresholds and samples set here
`default_nettype none

module tb_pqed_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        zca = 1'b0, zcb = 1'b0, zcc = 1'b0;
    logic [23:0] va = 24'h0, vb = 24'h0, vc = 24'h0, ne = 24'h0;
    logic [23:0] ia = 24'h0, ib = 24'h0, ic = 24'h0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, rdata;
    logic        sample_valid, int_n;
    logic [27:0] nrms;
    int          fail_count = 0, compares = 0;

    pqed_core_model #(.PERIOD(20)) pqed_core_model_inst (.clk(clk), .rst_b(rst_b),
        .sample_valid(sample_valid));
    pqed_top #(.SAMPLE_WIDTH(24), .CYC_WIDTH(8)) pqed_top_inst (.REF_CLK(clk),
        .RST_B(rst_b), .SAMPLE_VALID(sample_valid), .PHASE_A_VOLTAGE_SAMPLE(va),
        .PHASE_B_VOLTAGE_SAMPLE(vb), .PHASE_C_VOLTAGE_SAMPLE(vc),
        .PHASE_A_CURRENT_SAMPLE(ia), .PHASE_B_CURRENT_SAMPLE(ib),
        .PHASE_C_CURRENT_SAMPLE(ic), .NEUTRAL_CURRENT_SAMPLE(ne), .ZERO_CROSS_A(zca),
        .ZERO_CROSS_B(zcb), .ZERO_CROSS_C(zcc), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata),
        .EVENT_INT_N(int_n), .NEUTRAL_RMS_SOURCE(nrms));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic results();
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    task automatic pin(input logic e);
        #1;
        check({31'h0, int_n}, {31'h0, e});
    endtask

    // two strobes so one is certain to carry the newest samples
    task automatic pass();
        repeat (2) begin
            do @(posedge clk); while (sample_valid !== 1'b1);
        end
        repeat (3) @(posedge clk);
    endtask

    task automatic put(input logic [23:0] a, b, c, d, e, f, n);
        @(posedge clk);
        va <= a;
        vb <= b;
        vc <= c;
        ia <= d;
        ib <= e;
        ic <= f;
        ne <= n;
        pass();
    endtask

    task automatic zc();
        @(posedge clk);
        zca <= 1'b1;
        @(posedge clk);
        zca <= 1'b0;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        put(24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
        rd(8'h00, 32'h0016_0000);
        rd(8'h09, 32'h0);
        pin(1'b1);
        wr(8'h06, 32'hff51_4791);
        rd(8'h06, 32'h0051_4791);
        wr(8'h07, 32'h0051_4791);
        rd(8'h07, 32'h0051_4791);
        wr(8'h09, 32'h0080_0000);
        rd(8'h09, 32'h0f80_0000);
        wr(8'h09, 32'h0000_1000);
        wr(8'h01, 32'h0016_0000);
        put(24'h51_4791, 24'h0, 24'h0, 24'h51_4791, 24'h0, 24'h0, 24'h51_4791);
        wr(8'h00, 32'h0196_0000);
        pass();
        rd(8'h00, 32'h0);
        pin(1'b1);
        wr(8'h06, 32'h0000_0100);
        wr(8'h07, 32'h0000_0200);
        put(24'h0, 24'h00_0101, 24'hff_feff, 24'h00_0201, 24'h0, 24'h0, 24'h00_0201);
        rd(8'h00, 32'h0006_0000);
        rd(8'h02, 32'h0000_0c08);
        pin(1'b0);
        put(24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
        wr(8'h00, 32'h0004_0000);
        rd(8'h02, 32'h0000_0008);
        pin(1'b0);
        wr(8'h00, 32'h0002_0000);
        rd(8'h02, 32'h0);
        pin(1'b1);
        wr(8'h01, 32'h0014_0000);
        wr(8'h0a, 32'h0000_0004);
        put(24'h0, 24'h0, 24'h0, 24'hff_0000, 24'hff_0000, 24'hff_0000, 24'h02_f000);
        check({4'h0, nrms}, 32'h0ffd_0000);
        wr(8'h00, 32'h0196_0000);
        pass();
        rd(8'h00, 32'h0002_0000);
        pin(1'b1);
        put(24'h0, 24'h0, 24'h0, 24'hff_0000, 24'hff_0000, 24'hff_0000, 24'h02_efff);
        rd(8'h00, 32'h0012_0000);
        pin(1'b0);
        rd(8'h03, 32'h0002_0000);
        wr(8'h03, 32'h0002_0000);
        rd(8'h03, 32'h0);
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08, 32'h0ffd_0000);
        rd(8'h0d, 32'h0);
        wr(8'h0a, 32'h0);
        pass();
        check({4'h0, nrms}, 32'h0002_efff);
        put(24'h0, 24'h0, 24'h0, 24'hff_0000, 24'hff_0000, 24'hff_0000, 24'h02_f000);
        wr(8'h00, 32'h0010_0000);
        pin(1'b1);
        wr(8'h06, 32'h0);
        pass();
        wr(8'h00, 32'h0004_0000);
        pass();
        rd(8'h00, 32'h0006_0000);
        pin(1'b0);
        wr(8'h06, 32'h0051_4791);
        wr(8'h07, 32'h0051_4791);
        put(24'h00_0055, 24'h0, 24'h0, 24'h00_0123, 24'h0, 24'h0, 24'h00_0123);
        wr(8'h00, 32'h0196_0000);
        wr(8'h04, 32'h0000_0004);
        wr(8'h05, 32'h0000_0002);
        zc();
        wr(8'h05, 32'h0000_0002);
        zc();
        pass();
        rd(8'h00, 32'h0);
        zc();
        pass();
        rd(8'h00, 32'h0180_0000);
        rd(8'h0b, 32'h0100_0123);
        rd(8'h0c, 32'h0100_0055);
        wr(8'h00, 32'h0180_0000);
        rd(8'h00, 32'h0);
        results();
    end
endmodule

bind pqed_top pqed_top_sva #(.SAMPLE_WIDTH(SAMPLE_WIDTH), .CYC_WIDTH(CYC_WIDTH))
    pqed_top_sva_inst (.REF_CLK(REF_CLK), .RST_B(RST_B), .SAMPLE_VALID(SAMPLE_VALID),
    .PHASE_A_VOLTAGE_SAMPLE(PHASE_A_VOLTAGE_SAMPLE),
    .PHASE_B_VOLTAGE_SAMPLE(PHASE_B_VOLTAGE_SAMPLE),
    .PHASE_C_VOLTAGE_SAMPLE(PHASE_C_VOLTAGE_SAMPLE),
    .PHASE_A_CURRENT_SAMPLE(PHASE_A_CURRENT_SAMPLE),
    .PHASE_B_CURRENT_SAMPLE(PHASE_B_CURRENT_SAMPLE),
    .PHASE_C_CURRENT_SAMPLE(PHASE_C_CURRENT_SAMPLE),
    .NEUTRAL_CURRENT_SAMPLE(NEUTRAL_CURRENT_SAMPLE), .ZERO_CROSS_A(ZERO_CROSS_A),
    .ZERO_CROSS_B(ZERO_CROSS_B), .ZERO_CROSS_C(ZERO_CROSS_C), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .EVENT_INT_N(EVENT_INT_N), .NEUTRAL_RMS_SOURCE(NEUTRAL_RMS_SOURCE));

`default_nettype wire
